//--- verilog/hbc_pkg.sv
// package for the link message buffer and count control block
// assumes one system clock, synchronous active-high reset, plain register port
// Notes on behaviour
// - select bit reads 0 when tx buffer 0 is next free, 1 for buffer 1.
// - while a buffer is still being consumed, reads report the other buffer.
// - writing the select bit starts sending buffer 0 or buffer 1; here only from idle, a write arriving during a send starts nothing but still loads the count.
// - signaling type bit: 0 bit-oriented, 1 message-oriented; clear per bit message.
// - bit mode: count gives repetitions, then transfer-done and stop.
// - bit mode: count zero repeats forever without stopping.
// - message mode: count is length in octets with header, without check octets.
// - rx pointer bit shows which rx buffer holds the newest message.
// - bit mode: rx count sets receptions needed before rx transfer-done.
// - bit mode: rx count zero receives forever, no rx transfer-done.
// - message mode: rx count loaded with full received size incl. check octets.
// - eight-bit read-only identity register, writes ignored.
package hbc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] HBC_ADDR_PART_IDENTITY = 12'h1fe;
   localparam logic [11:0] HBC_ADDR_TX_BUF_COUNT  = 12'h040;
   localparam logic [11:0] HBC_ADDR_RX_BUF_COUNT  = 12'h044;
   localparam logic [11:0] HBC_ADDR_CONTROL       = 12'h048;
   localparam logic [11:0] HBC_ADDR_TX_BUF0       = 12'h600;
   localparam logic [11:0] HBC_ADDR_TX_BUF1       = 12'h700;
   // ----------------------------------------
   // fields and values
   // ----------------------------------------
   localparam int          HBC_SEL_BIT      = 7;
   localparam int          HBC_SIG_BIT      = 0;
   localparam logic [6:0]  HBC_COUNT_ZERO   = 7'h00;
   localparam logic [6:0]  HBC_COUNT_ONE    = 7'h01;
   localparam logic [7:0]  HBC_PART_ID      = 8'h5a; // arbitrary value
   localparam logic [7:0]  HBC_READ_ZERO    = 8'h00;
   localparam logic [7:0]  HBC_FLAG_OCTET   = 8'h7e;
   localparam logic [7:0]  HBC_BUF_MASK     = 8'hff;
   localparam int          HBC_BUF_DEPTH    = 128;
   localparam int          HBC_FIFO_DEPTH   = 16;
   typedef enum logic [1:0]
   {
      HBC_TX_IDLE = 2'b00,
      HBC_TX_SEND = 2'b01,
      HBC_TX_WAIT = 2'b10
   } hbc_tx_state_t;
endpackage

//--- verilog/hbc_msg_mem.sv
// two-bank message memory for the transmit buffers
// assumes one write port from software and one registered read port
`timescale 1ns/1ps
module hbc_msg_mem
   import hbc_pkg::*;
#(
   parameter int DEPTH = 256
)
(
   // clock
   input  wire logic              sys_clk,
   // write side
   input  wire logic              wr_en,
   input  wire logic [7:0]        wr_addr,
   input  wire logic [7:0]        wr_data,
   // read side
   input  wire logic [7:0]        rd_addr,
   output logic      [7:0]        rd_data
);
   logic [7:0] mem [DEPTH];
   initial
   begin
      if (DEPTH != 256)
      begin
         $error("depth must be 256");
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      rd_data <= mem[rd_addr];
   end
endmodule

//--- verilog/hbc_fifo.sv
// octet fifo between buffer reader and link side
// assumes drain side may stall by holding ready low
`timescale 1ns/1ps
module hbc_fifo
   import hbc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = HBC_FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              srst,
   // fill side
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire logic [WIDTH-1:0]  in_data,
   // drain side
   output logic                   out_valid,
   input  wire logic              out_ready,
   output logic      [WIDTH-1:0]  out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin
         $error("depth must be a power of two");
      end
   end
   assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) || 1'b0;
   assign out_valid = cnt_q != '0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rp_q];
   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wp_q] <= in_data;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q  <= push ? wp_q + AW'(1) : wp_q;
         rp_q  <= pop ? rp_q + AW'(1) : rp_q;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- verilog/hbc_ctrl.sv
// message buffer select and byte count control for link controller three
// assumes a plain register port; link side is an octet stream with ready
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module hbc_ctrl
   import hbc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // transmit octet stream toward the link
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic      [7:0]  tx_data,
   output logic             tx_msg_end,
   // receive events from the link side
   input  wire logic        rx_msg_done,
   input  wire logic [6:0]  rx_msg_size,
   // status
   output logic             tx_transfer_done_irq,
   output logic             rx_transfer_done_irq
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic          sig_msg_q;
   logic [6:0]    tx_msg_count_q;
   logic [6:0]    rx_msg_count_q;
   logic          rx_recent_buffer_pointer_q;
   logic          busy_q;
   logic          busy_buf_q;
   logic          next_free_q;
   hbc_tx_state_t st_q;
   logic [6:0]    idx_q;
   logic [6:0]    rep_q;
   logic [6:0]    rx_rep_q;
   logic          rd_last_q;
   logic [8:0]    fifo_out;
   logic [7:0]    rd_q;
   logic          tx_done_q;
   logic          rx_done_q;
   logic [7:0]    mem_rdata;
   logic          fifo_ready;
   logic          mem_wr;
   logic          sel_wr;
   logic          last_octet;
   logic          rd_valid_q;
   logic          read_sel;

   function automatic logic [7:0] buf_index(input logic b, input logic [6:0] i);
      buf_index = {b, i};
   endfunction

   assign mem_wr = reg_wr && (reg_addr[11:8] == HBC_ADDR_TX_BUF0[11:8]
                  || reg_addr[11:8] == HBC_ADDR_TX_BUF1[11:8])
                  && reg_addr[7] == 1'b0;
   assign sel_wr = reg_wr && reg_addr == HBC_ADDR_TX_BUF_COUNT;
   // the buffer not in use is the one to report
   assign read_sel = busy_q ? ~busy_buf_q : next_free_q;

   // ----------------------------------------
   // memory and fifo
   // ----------------------------------------
   hbc_msg_mem #(.DEPTH(2 * HBC_BUF_DEPTH)) u_mem
   (
      .sys_clk (sys_clk),
      .wr_en   (mem_wr),
      .wr_addr (buf_index(reg_addr[8], reg_addr[6:0])),
      .wr_data (reg_wdata),
      .rd_addr (buf_index(busy_buf_q, idx_q)),
      .rd_data (mem_rdata)
   );

   hbc_fifo #(.WIDTH(9), .DEPTH(HBC_FIFO_DEPTH)) u_fifo
   (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .in_valid  (rd_valid_q),
      .in_ready  (fifo_ready),
      .in_data   ({rd_last_q, mem_rdata}),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (fifo_out)
   );

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sig_msg_q      <= 1'b0;
         tx_msg_count_q <= HBC_COUNT_ZERO;
      end
      else
      begin
         if (reg_wr && reg_addr == HBC_ADDR_CONTROL)
         begin
            sig_msg_q <= reg_wdata[HBC_SIG_BIT];
         end
         if (sel_wr)
         begin
            tx_msg_count_q <= reg_wdata[6:0];
         end
      end
   end

   // ----------------------------------------
   // receive side
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rx_msg_count_q             <= HBC_COUNT_ZERO;
         rx_recent_buffer_pointer_q <= 1'b0;
         rx_rep_q                   <= HBC_COUNT_ZERO;
         rx_done_q                  <= 1'b0;
      end
      else
      begin
         rx_done_q <= 1'b0;
         if (rx_msg_done)
         begin
            rx_recent_buffer_pointer_q <= ~rx_recent_buffer_pointer_q;
            if (sig_msg_q)
            begin
               rx_msg_count_q <= rx_msg_size;
               rx_done_q      <= 1'b1;
            end
            else if (rx_msg_count_q != HBC_COUNT_ZERO)
            begin
               if (rx_rep_q + HBC_COUNT_ONE >= rx_msg_count_q)
               begin
                  rx_done_q <= 1'b1;
                  rx_rep_q  <= HBC_COUNT_ZERO;
               end
               else
               begin
                  rx_rep_q <= rx_rep_q + HBC_COUNT_ONE;
               end
            end
         end
         else if (reg_wr && reg_addr == HBC_ADDR_RX_BUF_COUNT)
         begin
            rx_msg_count_q <= reg_wdata[6:0];
            rx_rep_q       <= HBC_COUNT_ZERO;
         end
      end
   end
   assign rx_transfer_done_irq = rx_done_q;

   // ----------------------------------------
   // transmit sequencer
   // ----------------------------------------
   // bit mode sends a one-octet pattern; message mode sends count octets
   assign last_octet = sig_msg_q ? (idx_q + HBC_COUNT_ONE >= tx_msg_count_q)
                                 : 1'b1;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_q        <= HBC_TX_IDLE;
         busy_q      <= 1'b0;
         busy_buf_q  <= 1'b0;
         next_free_q <= 1'b0;
         idx_q       <= HBC_COUNT_ZERO;
         rep_q       <= HBC_COUNT_ZERO;
         rd_valid_q  <= 1'b0;
         rd_last_q   <= 1'b0;
         tx_done_q   <= 1'b0;
      end
      else
      begin
         tx_done_q  <= 1'b0;
         rd_valid_q <= 1'b0;
         unique case (st_q)
            HBC_TX_IDLE:
            begin
               // a select write starts a send only here in idle; one arriving during a send starts nothing, whichever buffer it names, but its count is still loaded
               if (sel_wr && !(busy_q && reg_wdata[HBC_SEL_BIT] == busy_buf_q))
               begin
                  busy_q      <= 1'b1;
                  busy_buf_q  <= reg_wdata[HBC_SEL_BIT];
                  next_free_q <= ~reg_wdata[HBC_SEL_BIT];
                  idx_q       <= HBC_COUNT_ZERO;
                  rep_q       <= HBC_COUNT_ZERO;
                  st_q        <= HBC_TX_SEND;
               end
            end
            HBC_TX_SEND:
            begin
               // fifo back-pressure stalls the reader
               if (fifo_ready && !rd_valid_q)
               begin
                  rd_valid_q <= 1'b1;
                  rd_last_q  <= last_octet;
                  st_q       <= HBC_TX_WAIT;
               end
            end
            HBC_TX_WAIT:
            begin
               if (!last_octet)
               begin
                  idx_q <= idx_q + HBC_COUNT_ONE;
                  st_q  <= HBC_TX_SEND;
               end
               else if (!sig_msg_q && (tx_msg_count_q == HBC_COUNT_ZERO
                        || rep_q + HBC_COUNT_ONE < tx_msg_count_q))
               begin
                  rep_q <= rep_q + HBC_COUNT_ONE;
                  idx_q <= HBC_COUNT_ZERO;
                  st_q  <= HBC_TX_SEND;
               end
               else
               begin
                  busy_q    <= 1'b0;
                  tx_done_q <= 1'b1;
                  st_q      <= HBC_TX_IDLE;
               end
            end
            default:
            begin
               st_q <= HBC_TX_IDLE;
            end
         endcase
      end
   end
   assign tx_transfer_done_irq = tx_done_q;

   // ----------------------------------------
   // link octet framing
   // ----------------------------------------
   // end mark rides in the fifo beside its octet, so stalls cannot skew it
   assign tx_data    = fifo_out[7:0];
   assign tx_msg_end = fifo_out[8];

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rd_q <= HBC_READ_ZERO;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            HBC_ADDR_PART_IDENTITY: rd_q <= HBC_PART_ID;
            HBC_ADDR_TX_BUF_COUNT:  rd_q <= {read_sel, tx_msg_count_q};
            HBC_ADDR_RX_BUF_COUNT:  rd_q <= {rx_recent_buffer_pointer_q,
                                             rx_msg_count_q};
            HBC_ADDR_CONTROL:       rd_q <= {7'h00, sig_msg_q};
            default:                rd_q <= HBC_READ_ZERO;
         endcase
      end
      else
      begin
         rd_q <= HBC_READ_ZERO;
      end
   end
   assign reg_rdata = rd_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_sel_write;
      sel_wr && st_q == HBC_TX_IDLE;
   endsequence
   sequence s_msg_last;
      st_q == HBC_TX_WAIT && sig_msg_q && last_octet;
   endsequence
   sequence s_bit_last;
      st_q == HBC_TX_WAIT && !sig_msg_q && tx_msg_count_q != HBC_COUNT_ZERO
         && rep_q + HBC_COUNT_ONE >= tx_msg_count_q;
   endsequence
   AST_PART_ID: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == HBC_ADDR_PART_IDENTITY |=> reg_rdata == HBC_PART_ID)
      else $error("identity readback wrong");
   AST_SEL_READ: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == HBC_ADDR_TX_BUF_COUNT |=> reg_rdata[7] == $past(read_sel))
      else $error("select readback wrong");
   AST_BUSY_OTHER: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == HBC_ADDR_TX_BUF_COUNT && busy_q
      |=> reg_rdata[HBC_SEL_BIT] != $past(busy_buf_q))
      else $error("select reports busy buffer");
   AST_START: assert property (@(posedge sys_clk) disable iff (srst)
      s_sel_write |=> busy_q && busy_buf_q == $past(reg_wdata[HBC_SEL_BIT]))
      else $error("send not started");
   AST_DONE_FREE: assert property (@(posedge sys_clk) disable iff (srst)
      tx_done_q |-> !busy_q && st_q == HBC_TX_IDLE)
      else $error("buffer not freed");
   AST_ENDLESS: assert property (@(posedge sys_clk) disable iff (srst)
      !sig_msg_q && tx_msg_count_q == HBC_COUNT_ZERO && busy_q |=> !tx_done_q)
      else $error("endless send stopped");
   AST_RX_ENDLESS: assert property (@(posedge sys_clk) disable iff (srst)
      !sig_msg_q && rx_msg_count_q == HBC_COUNT_ZERO |=> !rx_done_q)
      else $error("rx done with zero count");
   AST_RX_SIZE: assert property (@(posedge sys_clk) disable iff (srst)
      rx_msg_done && sig_msg_q |=> rx_msg_count_q == $past(rx_msg_size))
      else $error("rx size not loaded");
   AST_RX_PTR: assert property (@(posedge sys_clk) disable iff (srst)
      rx_msg_done |=> rx_recent_buffer_pointer_q != $past(rx_recent_buffer_pointer_q))
      else $error("rx pointer not moved");
   AST_START_IDX: assert property (@(posedge sys_clk) disable iff (srst)
      s_sel_write |=> st_q == HBC_TX_SEND && idx_q == HBC_COUNT_ZERO && rep_q == HBC_COUNT_ZERO)
      else $error("send not set up");
   AST_SEL_REFUSED: assert property (@(posedge sys_clk) disable iff (srst)
      sel_wr && st_q != HBC_TX_IDLE |=> $stable(busy_buf_q))
      else $error("select write taken while sending");
   AST_MSG_STOP: assert property (@(posedge sys_clk) disable iff (srst)
      s_msg_last |=> tx_done_q && !busy_q)
      else $error("message send did not stop");
   AST_BIT_STOP: assert property (@(posedge sys_clk) disable iff (srst)
      s_bit_last |=> tx_done_q && !busy_q)
      else $error("repeat count not honoured");
   AST_ENDLESS_RUN: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == HBC_TX_WAIT && !sig_msg_q && tx_msg_count_q == HBC_COUNT_ZERO
      |=> st_q == HBC_TX_SEND)
      else $error("endless send not repeated");
   AST_FIFO_ROOM: assert property (@(posedge sys_clk) disable iff (srst)
      rd_valid_q |-> fifo_ready)
      else $error("octet pushed into full fifo");
   AST_TX_DONE_ONE: assert property (@(posedge sys_clk) disable iff (srst)
      tx_done_q |=> !tx_done_q)
      else $error("tx done pulse too long");
   AST_BUF_SWAP: assert property (@(posedge sys_clk) disable iff (srst)
      tx_done_q |-> read_sel != busy_buf_q)
      else $error("freed buffer not offered");
   AST_RX_DONE_CAUSE: assert property (@(posedge sys_clk) disable iff (srst)
      rx_done_q |-> $past(rx_msg_done))
      else $error("rx done without message");
   AST_RX_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      rx_msg_done && !sig_msg_q |=> $stable(rx_msg_count_q))
      else $error("rx repeat count disturbed");
   AST_RX_MSG_DONE: assert property (@(posedge sys_clk) disable iff (srst)
      rx_msg_done && sig_msg_q |=> rx_done_q)
      else $error("rx message done missing");
endmodule

//--- verif/hbc_link_model.sv
// link-side partner: drains the transmit octet stream and posts receive events
// assumes the bench paces it through slow and stall and calls send_msg after an edge
`timescale 1ns/1ps
module hbc_link_model
   import hbc_pkg::*;
(
   // clock
   input  wire logic       sys_clk,
   // pacing from the bench
   input  wire logic       slow,
   input  wire logic       stall,
   // transmit stream
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_msg_end,
   // receive events
   output logic            rx_msg_done,
   output logic [6:0]      rx_msg_size
);
   logic       phase_q;
   logic [7:0] got[$];
   int         ends;

   initial
   begin
      phase_q     = 1'b0;
      ends        = 0;
      rx_msg_done = 1'b0;
      rx_msg_size = 7'h55;
   end

   // slow mode accepts every other cycle, so the fifo sees a stalling sink
   always @(posedge sys_clk) phase_q <= ~phase_q;
   assign tx_ready = !stall && (!slow || phase_q);

   always @(posedge sys_clk)
   begin
      if (tx_valid && tx_ready)
      begin
         got.push_back(tx_data);
         if (tx_msg_end)
            ends++;
      end
   end

   // size is only meaningful beside the pulse; inverted afterwards, not held
   task send_msg(input logic [6:0] size);
      @(posedge sys_clk);
      rx_msg_done <= 1'b1;
      rx_msg_size <= size;
      @(posedge sys_clk);
      rx_msg_done <= 1'b0;
      rx_msg_size <= ~size;
   endtask
endmodule

//--- verif/hbc_ctrl_tb.sv
// self-checking bench for the link buffer select and count control
// assumes the link partner model and the register map of the package
`timescale 1ns/1ps
module hbc_ctrl_tb
   import hbc_pkg::*;
;
   logic        sys_clk, srst, reg_wr, reg_rd, tx_valid, tx_ready, slow, stall;
   logic        rx_msg_done, tx_irq, rx_irq, tx_end;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, tx_data, rd, p, tx_irq_n, rx_irq_n;
   logic [6:0]  rx_msg_size;
   int          errors, num_checks, cycles;

   hbc_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_msg_end(tx_end),
      .rx_msg_done(rx_msg_done), .rx_msg_size(rx_msg_size),
      .tx_transfer_done_irq(tx_irq), .rx_transfer_done_irq(rx_irq));

   hbc_link_model u_link (.sys_clk(sys_clk), .slow(slow), .stall(stall),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_msg_end(tx_end),
      .rx_msg_done(rx_msg_done), .rx_msg_size(rx_msg_size));

   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   // ----------------------------------------
   // pulse counters and hang guard
   // ----------------------------------------
   always @(posedge sys_clk)
   begin
      if (tx_irq === 1'b1) tx_irq_n <= tx_irq_n + 8'h01;
      if (rx_irq === 1'b1) rx_irq_n <= rx_irq_n + 8'h01;
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task rdreg(input logic [11:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task wait_tx(input logic [7:0] n);
      for (int k = 0; k < 600 && tx_irq_n !== n; k++) @(posedge sys_clk);
   endtask

   task check_got(input int n, input logic [7:0] exp);
      check(8'(u_link.got.size()), 8'(n));
      for (int i = 0; i < n; i++) check(u_link.got[i], exp);
   endtask

   task check_sel(input logic [7:0] exp);
      rdreg(HBC_ADDR_TX_BUF_COUNT, rd);
      check({7'h00, rd[HBC_SEL_BIT]}, exp);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset_and_identity;
      check({7'h00, tx_valid}, 8'h00);
      rdreg(HBC_ADDR_TX_BUF_COUNT, rd);
      check(rd, 8'h00);
      wr(HBC_ADDR_PART_IDENTITY, 8'ha5);
      rdreg(HBC_ADDR_PART_IDENTITY, rd);
      check(rd, HBC_PART_ID);
      rdreg(12'h123, rd);
      check(rd, HBC_READ_ZERO);
   endtask

   // long repeat counts outrun the fifo so the buffer is still busy when read
   task t_bit_repeat;
      wr(HBC_ADDR_TX_BUF0, 8'ha5);
      wr(HBC_ADDR_TX_BUF1, 8'h3c);
      wr(HBC_ADDR_CONTROL, 8'h00);
      u_link.got.delete();
      stall <= 1'b1;
      wr(HBC_ADDR_TX_BUF_COUNT, 8'h14);
      idle(30);
      check_sel(8'h01);
      slow  <= 1'b1;
      stall <= 1'b0;
      wait_tx(8'h01);
      idle(60);
      check_got(20, 8'ha5);
      check_sel(8'h01);
      u_link.got.delete();
      stall <= 1'b1;
      wr(HBC_ADDR_TX_BUF_COUNT, 8'h91);
      idle(30);
      check_sel(8'h00);
      stall <= 1'b0;
      wait_tx(8'h02);
      idle(60);
      check_got(17, 8'h3c);
      check_sel(8'h00);
   endtask

   task t_endless;
      wr(HBC_ADDR_TX_BUF_COUNT, 8'h00);
      stall <= 1'b1;
      idle(60);
      stall <= 1'b0;
      idle(200);
      check(tx_irq_n, 8'h02);
      check({7'h00, tx_valid}, 8'h01);
      srst <= 1'b1;
      idle(3);
      srst <= 1'b0;
      idle(2);
      check({7'h00, tx_valid}, 8'h00);
   endtask

   task t_message_tx;
      wr(HBC_ADDR_CONTROL, 8'h01);
      for (int i = 0; i < 4; i++) wr(HBC_ADDR_TX_BUF0 + 12'(i), 8'h10 + 8'(i));
      u_link.got.delete();
      u_link.ends = 0;
      wr(HBC_ADDR_TX_BUF_COUNT, 8'h04);
      idle(80);
      for (int i = 0; i < 4; i++) check(u_link.got[i], 8'h10 + 8'(i));
      check(8'(u_link.got.size()), 8'h04);
      check(8'(u_link.ends), 8'h01);
      check(tx_irq_n, 8'h03);
   endtask

   task t_receive;
      wr(HBC_ADDR_CONTROL, 8'h00);
      wr(HBC_ADDR_RX_BUF_COUNT, 8'h02);
      rdreg(HBC_ADDR_RX_BUF_COUNT, p);
      u_link.send_msg(7'h05);
      idle(4);
      check(rx_irq_n, 8'h00);
      rdreg(HBC_ADDR_RX_BUF_COUNT, rd);
      check({7'h00, rd[7]}, {7'h00, ~p[7]});
      u_link.send_msg(7'h05);
      idle(4);
      check(rx_irq_n, 8'h01);
      wr(HBC_ADDR_RX_BUF_COUNT, 8'h00);
      repeat (3) u_link.send_msg(7'h05);
      idle(4);
      check(rx_irq_n, 8'h01);
      wr(HBC_ADDR_CONTROL, 8'h01);
      rdreg(HBC_ADDR_RX_BUF_COUNT, p);
      u_link.send_msg(7'h25);
      idle(4);
      rdreg(HBC_ADDR_RX_BUF_COUNT, rd);
      check({1'b0, rd[6:0]}, 8'h25);
      check({7'h00, rd[7]}, {7'h00, ~p[7]});
      check(rx_irq_n, 8'h02);
   endtask

   initial
   begin
      srst      = 1'b1;
      reg_addr  = 12'h000;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      slow      = 1'b0;
      stall     = 1'b0;
      tx_irq_n  = 8'h00;
      rx_irq_n  = 8'h00;
      errors     = 0;
      num_checks = 0;
      cycles     = 0;
      idle(3);
      srst <= 1'b0;
      t_reset_and_identity();
      t_bit_repeat();
      t_endless();
      t_message_tx();
      t_receive();
      end_of_test();
   end
endmodule
